// ### rtl/ppl_pkg.sv
// shared constants and types of the parallel programming loader
package ppl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ENTRY_GUARD_NS = 100;
  localparam int unsigned ENTRY_GUARD_CYC = (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ENTRY_GUARD_LAST = 4'(ENTRY_GUARD_CYC - 1);
  localparam int unsigned BUSY_NS = 1000;
  localparam int unsigned BUSY_CYC = BUSY_NS / CLK_PERIOD_NS;
  localparam logic [7:0] BUSY_LAST = 8'(BUSY_CYC - 1);
  localparam logic [2:0] ENTRY_TOGGLES = 3'h6;
  localparam logic [3:0] ENTRY_SEL_CODE = 4'h0;

  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  localparam int unsigned FLASH_ADDR_TOP = 12;
  localparam int unsigned FLASH_AW = FLASH_ADDR_TOP + 1;
  localparam int unsigned FLASH_WORDS = 1 << FLASH_AW;
  localparam int unsigned PAGE_AW = 6;
  localparam int unsigned PAGE_WORDS = 1 << PAGE_AW;
  localparam int unsigned EE_ADDR_TOP = 8;
  localparam int unsigned EE_AW = EE_ADDR_TOP + 1;
  localparam int unsigned EE_BYTES = 1 << EE_AW;
  localparam int unsigned EE_PAGE_AW = 2;
  localparam logic [FLASH_AW-1:0] FLASH_LAST = {FLASH_AW{1'b1}};
  localparam logic [FLASH_AW-1:0] EE_LAST = FLASH_AW'(EE_BYTES - 1);
  localparam logic [FLASH_AW-1:0] PAGE_LAST = FLASH_AW'(PAGE_WORDS - 1);
  localparam logic [FLASH_AW-1:0] EE_PAGE_LAST = FLASH_AW'((1 << EE_PAGE_AW) - 1);

  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] FUSE_LOW_RST = 8'h62;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hDF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hF9;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam int unsigned PRESERVE_BIT = 3;

  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_W = PAGE_AW + 16;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DRAIN, ST_PROG_F, ST_PROG_E, ST_ER_FLASH, ST_ER_EE, ST_ER_LOCK, ST_SETTLE
  } ppl_state_t;

  typedef enum logic [1:0] {EN_OFF, EN_GUARD, EN_ON, EN_FAIL} ppl_entry_t;
endpackage

// ### rtl/ppl_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ppl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/ppl_loader.sv
// parallel programming port of the device: entry, loads, page buffer, erase and program
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (RULE_01) programmer: reset low, six strobes, select 0000
// (RULE_02) select change in 100 ns fails entry
// (RULE_03) programmer waits 50 us before commands
// (RULE_04) load strobe: address, data, command, or idle
// (RULE_05) byte select one picks low/high byte
// (RULE_06) decode erase, fuse write, lock write
// (RULE_07) decode flash write and eeprom write
// (RULE_08) decode signature, fuse, flash, eeprom reads
// (RULE_09) command and address kept across operations
// (RULE_10) programmer reloads high byte per window
// (RULE_11) page buffer of words, programmed at once
// (RULE_12) eeprom pages of four bytes
// (RULE_13) upper low-byte bits select the page
// (RULE_14) erase flash, eeprom, then locks; fuses kept
// (RULE_15) preserve fuse keeps eeprom through erase
// (RULE_16) programmer erases before reprogramming
// (RULE_17) write strobe after erase command: busy
// (RULE_18) data bytes latched into buffer by page latch
// (RULE_19) programmer repeats loads until page loaded
// (RULE_20) write strobe programs page, busy until done
// (RULE_21) ready_busy low busy, high ready
// (RULE_22) data bus driven only while output enable low
// (RULE_23) byte select two picks second high byte
// (RULE_24) unknown command: write strobe starts nothing
module ppl_loader #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic reset_low_i,
  input wire logic hv_on_i,
  input wire logic load_strobe_i,
  input wire logic action_select_high_i,
  input wire logic action_select_low_i,
  input wire logic byte_select_one_i,
  input wire logic byte_select_two_i,
  input wire logic page_latch_strobe_i,
  input wire logic write_n_i,
  input wire logic oe_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic ready_busy_o,
  output logic prog_mode_o,
  output logic latch_ready_o
);
  logic ls_q;
  logic wr_n_q;
  logic pl_q;
  logic hv_q;
  logic ls_rise;
  logic wr_fall;
  logic pl_rise;
  logic hv_rise;
  logic [3:0] entry_sel;
  logic [2:0] toggles_q;
  logic [3:0] guard_q;
  ppl_pkg::ppl_entry_t entry_q;
  ppl_pkg::ppl_entry_t entry_d;
  ppl_pkg::ppl_state_t state_q;
  ppl_pkg::ppl_state_t state_d;
  logic [ppl_pkg::FLASH_AW-1:0] idx_q;
  logic [7:0] timer_q;
  logic [7:0] cmd_q;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_hi_q;
  logic [7:0] data_lo_q;
  logic [7:0] data_hi_q;
  logic [7:0] fuse_lo_q;
  logic [7:0] fuse_hi_q;
  logic [7:0] fuse_ext_q;
  logic [7:0] lock_q;
  logic [15:0] flash_mem [ppl_pkg::FLASH_WORDS];
  logic [7:0] ee_mem [ppl_pkg::EE_BYTES];
  logic [15:0] pbuf [ppl_pkg::PAGE_WORDS];
  logic [ppl_pkg::PAGE_WORDS-1:0] pvalid_q;
  logic [ppl_pkg::FLASH_AW-1:0] flash_addr;
  logic [ppl_pkg::EE_AW-1:0] ee_addr;
  logic [15:0] addr_full;
  logic can_load;
  logic preserve;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [ppl_pkg::FIFO_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ppl_pkg::FIFO_W-1:0] fifo_out_data;
  logic [ppl_pkg::PAGE_AW-1:0] drain_idx;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;

  function automatic logic is_write_cmd(input logic [7:0] c);
    is_write_cmd = (c == ppl_pkg::CMD_ERASE) || (c == ppl_pkg::CMD_WR_FUSE) ||
                   (c == ppl_pkg::CMD_WR_LOCK) || (c == ppl_pkg::CMD_WR_FLASH) ||
                   (c == ppl_pkg::CMD_WR_EE);
  endfunction

  assign ls_rise = load_strobe_i & ~ls_q;
  assign wr_fall = ~write_n_i & wr_n_q;
  assign pl_rise = page_latch_strobe_i & ~pl_q;
  assign hv_rise = hv_on_i & ~hv_q;
  assign entry_sel = {page_latch_strobe_i, action_select_high_i, action_select_low_i, byte_select_one_i};
  assign can_load = (entry_q == ppl_pkg::EN_ON) && (state_q == ppl_pkg::ST_IDLE);
  assign addr_full = {addr_hi_q, addr_lo_q};
  assign flash_addr = addr_full[ppl_pkg::FLASH_AW-1:0];
  assign ee_addr = addr_full[ppl_pkg::EE_AW-1:0];
  // preserve fuse acts as soon as written, no latching
  assign preserve = ~fuse_hi_q[ppl_pkg::PRESERVE_BIT];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ls_q <= 1'b0;
      wr_n_q <= 1'b1;
      pl_q <= 1'b0;
      hv_q <= 1'b0;
    end else begin
      ls_q <= load_strobe_i;
      wr_n_q <= write_n_i;
      pl_q <= page_latch_strobe_i;
      hv_q <= hv_on_i;
    end
  end

  // strobe count while reset pin held low
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !hv_on_i && !reset_low_i) begin
      toggles_q <= '0;
    end else if (reset_low_i && !hv_on_i && ls_rise && toggles_q != ppl_pkg::ENTRY_TOGGLES) begin
      toggles_q <= toggles_q + 1'b1; // RULE_01
    end
  end

  always_comb begin
    entry_d = entry_q;
    case (entry_q)
      ppl_pkg::EN_OFF: begin
        if (hv_rise) begin
          if (toggles_q == ppl_pkg::ENTRY_TOGGLES && entry_sel == ppl_pkg::ENTRY_SEL_CODE) begin
            entry_d = ppl_pkg::EN_GUARD; // RULE_01
          end else begin
            entry_d = ppl_pkg::EN_FAIL;
          end
        end
      end
      ppl_pkg::EN_GUARD: begin
        if (entry_sel != ppl_pkg::ENTRY_SEL_CODE) begin
          entry_d = ppl_pkg::EN_FAIL; // RULE_02
        end else if (guard_q == ppl_pkg::ENTRY_GUARD_LAST) begin
          entry_d = ppl_pkg::EN_ON;
        end
      end
      default: begin
        entry_d = entry_q;
      end
    endcase
    if (!hv_on_i) begin
      entry_d = ppl_pkg::EN_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      entry_q <= ppl_pkg::EN_OFF;
      guard_q <= '0;
      prog_mode_o <= 1'b0;
    end else begin
      entry_q <= entry_d;
      guard_q <= (entry_q == ppl_pkg::EN_GUARD) ? guard_q + 1'b1 : '0; // RULE_02
      prog_mode_o <= (entry_d == ppl_pkg::EN_ON);
    end
  end

  // loads are refused while busy; the programmer must wait for ready
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd_q <= ppl_pkg::CMD_NOP;
      addr_lo_q <= '0;
      addr_hi_q <= '0;
      data_lo_q <= '0;
      data_hi_q <= '0;
    end else if (can_load && ls_rise) begin
      case ({action_select_high_i, action_select_low_i}) // RULE_04
        ppl_pkg::ACT_ADDR: begin
          if (byte_select_one_i) begin
            addr_hi_q <= data_i; // RULE_05
          end else begin
            addr_lo_q <= data_i;
          end
        end
        ppl_pkg::ACT_DATA: begin
          if (byte_select_one_i) begin
            data_hi_q <= data_i; // RULE_05
          end else begin
            data_lo_q <= data_i;
          end
        end
        ppl_pkg::ACT_CMD: begin
          cmd_q <= data_i; // RULE_09
        end
        default: begin
          cmd_q <= cmd_q;
        end
      endcase
    end
  end

  // page latch pushes word index plus both data bytes for flash, low byte only for eeprom
  always_comb begin
    fifo_in_valid = can_load && pl_rise && (cmd_q == ppl_pkg::CMD_WR_FLASH || cmd_q == ppl_pkg::CMD_WR_EE);
    if (cmd_q == ppl_pkg::CMD_WR_EE) begin
      fifo_in_data = {(ppl_pkg::PAGE_AW)'(addr_lo_q[ppl_pkg::EE_PAGE_AW-1:0]), 8'h00, data_lo_q}; // RULE_12
    end else begin
      fifo_in_data = {addr_lo_q[ppl_pkg::PAGE_AW-1:0], data_hi_q, data_lo_q}; // RULE_18
    end
  end

  // drain stalls while the page is committed; latches are refused then too, so the fifo cannot fill
  assign fifo_out_ready = (state_q == ppl_pkg::ST_IDLE) || (state_q == ppl_pkg::ST_DRAIN);
  assign drain_idx = fifo_out_data[ppl_pkg::FIFO_W-1:16];

  ppl_fifo #(
    .WIDTH(ppl_pkg::FIFO_W),
    .DEPTH(ppl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge clk_i) begin
    if (fifo_out_valid && fifo_out_ready) begin
      pbuf[drain_idx] <= fifo_out_data[15:0]; // RULE_18
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pvalid_q <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      pvalid_q[drain_idx] <= 1'b1; // RULE_11
    end else if (state_q == ppl_pkg::ST_SETTLE && timer_q == '0) begin
      pvalid_q <= '0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ppl_pkg::ST_IDLE: begin
        if (entry_q == ppl_pkg::EN_ON && wr_fall && is_write_cmd(cmd_q)) begin // RULE_24
          case (cmd_q)
            ppl_pkg::CMD_ERASE: state_d = ppl_pkg::ST_ER_FLASH; // RULE_17
            ppl_pkg::CMD_WR_FLASH: state_d = ppl_pkg::ST_DRAIN; // RULE_20
            ppl_pkg::CMD_WR_EE: state_d = ppl_pkg::ST_DRAIN; // RULE_07
            default: state_d = ppl_pkg::ST_SETTLE;
          endcase
        end
      end
      ppl_pkg::ST_DRAIN: begin
        if (!fifo_out_valid) begin
          state_d = (cmd_q == ppl_pkg::CMD_WR_EE) ? ppl_pkg::ST_PROG_E : ppl_pkg::ST_PROG_F;
        end
      end
      ppl_pkg::ST_PROG_F: begin
        if (idx_q == ppl_pkg::PAGE_LAST) begin
          state_d = ppl_pkg::ST_SETTLE;
        end
      end
      ppl_pkg::ST_PROG_E: begin
        if (idx_q == ppl_pkg::EE_PAGE_LAST) begin
          state_d = ppl_pkg::ST_SETTLE;
        end
      end
      ppl_pkg::ST_ER_FLASH: begin
        if (idx_q == ppl_pkg::FLASH_LAST) begin
          state_d = preserve ? ppl_pkg::ST_ER_LOCK : ppl_pkg::ST_ER_EE; // RULE_15
        end
      end
      ppl_pkg::ST_ER_EE: begin
        if (idx_q == ppl_pkg::EE_LAST) begin
          state_d = ppl_pkg::ST_ER_LOCK;
        end
      end
      ppl_pkg::ST_ER_LOCK: begin
        state_d = ppl_pkg::ST_SETTLE;
      end
      ppl_pkg::ST_SETTLE: begin
        if (timer_q == ppl_pkg::BUSY_LAST) begin
          state_d = ppl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = ppl_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= ppl_pkg::ST_IDLE;
      idx_q <= '0;
      timer_q <= '0;
      ready_busy_o <= 1'b1;
    end else begin
      state_q <= state_d;
      idx_q <= (state_d == state_q) ? idx_q + 1'b1 : '0;
      timer_q <= (state_q == ppl_pkg::ST_SETTLE && state_d == state_q) ? timer_q + 1'b1 : '0;
      ready_busy_o <= (state_d == ppl_pkg::ST_IDLE); // RULE_21
    end
  end

  // page number from high byte plus upper low-byte bits
  always_ff @(posedge clk_i) begin
    if (state_q == ppl_pkg::ST_PROG_F && pvalid_q[idx_q[ppl_pkg::PAGE_AW-1:0]]) begin
      flash_mem[{flash_addr[ppl_pkg::FLASH_ADDR_TOP:ppl_pkg::PAGE_AW], idx_q[ppl_pkg::PAGE_AW-1:0]}] <=
        pbuf[idx_q[ppl_pkg::PAGE_AW-1:0]]; // RULE_13
    end else if (state_q == ppl_pkg::ST_ER_FLASH) begin
      flash_mem[idx_q] <= ppl_pkg::ERASED_WORD; // RULE_14
    end
  end

  always_ff @(posedge clk_i) begin
    if (state_q == ppl_pkg::ST_PROG_E && pvalid_q[idx_q[ppl_pkg::PAGE_AW-1:0]]) begin
      ee_mem[{ee_addr[ppl_pkg::EE_ADDR_TOP:ppl_pkg::EE_PAGE_AW], idx_q[ppl_pkg::EE_PAGE_AW-1:0]}] <=
        pbuf[idx_q[ppl_pkg::PAGE_AW-1:0]][7:0]; // RULE_12
    end else if (state_q == ppl_pkg::ST_ER_EE) begin
      ee_mem[idx_q[ppl_pkg::EE_AW-1:0]] <= ppl_pkg::ERASED_BYTE; // RULE_14
    end
  end

  // fuses survive erase; lock bits only program toward zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fuse_lo_q <= ppl_pkg::FUSE_LOW_RST;
      fuse_hi_q <= ppl_pkg::FUSE_HIGH_RST;
      fuse_ext_q <= ppl_pkg::FUSE_EXT_RST;
      lock_q <= ppl_pkg::LOCK_RST;
    end else if (state_q == ppl_pkg::ST_ER_LOCK) begin
      lock_q <= ppl_pkg::LOCK_RST; // RULE_14
    end else if (state_q == ppl_pkg::ST_IDLE && entry_q == ppl_pkg::EN_ON && wr_fall) begin
      if (cmd_q == ppl_pkg::CMD_WR_LOCK) begin
        lock_q <= lock_q & data_lo_q; // RULE_06
      end else if (cmd_q == ppl_pkg::CMD_WR_FUSE) begin
        case ({byte_select_two_i, byte_select_one_i}) // RULE_23
          2'b01: fuse_hi_q <= data_lo_q;
          2'b10: fuse_ext_q <= data_lo_q;
          2'b00: fuse_lo_q <= data_lo_q;
          default: fuse_lo_q <= fuse_lo_q;
        endcase
      end
    end
  end

  always_comb begin
    rd_word = flash_mem[flash_addr];
    case (cmd_q) // RULE_08
      ppl_pkg::CMD_RD_FLASH: rd_byte = byte_select_one_i ? rd_word[15:8] : rd_word[7:0];
      ppl_pkg::CMD_RD_EE: rd_byte = ee_mem[ee_addr];
      ppl_pkg::CMD_RD_FUSE: begin
        case ({byte_select_two_i, byte_select_one_i})
          2'b00: rd_byte = fuse_lo_q;
          2'b11: rd_byte = fuse_hi_q;
          2'b10: rd_byte = fuse_ext_q;
          default: rd_byte = lock_q;
        endcase
      end
      ppl_pkg::CMD_RD_SIG: begin
        if (byte_select_one_i) begin
          rd_byte = CAL_BYTE;
        end else begin
          case (addr_lo_q[1:0])
            2'b00: rd_byte = SIG_BYTE0;
            2'b01: rd_byte = SIG_BYTE1;
            2'b10: rd_byte = SIG_BYTE2;
            default: rd_byte = 8'h00;
          endcase
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // one cycle from output enable to drive; no drive outside programming
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
      latch_ready_o <= 1'b1;
    end else begin
      data_o <= rd_byte;
      data_oe_n_o <= oe_n_i | (entry_q != ppl_pkg::EN_ON); // RULE_22
      latch_ready_o <= fifo_in_ready;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_ERASE_BUSY: assert property ( // RULE_17
    can_load && wr_fall && cmd_q == ppl_pkg::CMD_ERASE |=> !ready_busy_o && state_q == ppl_pkg::ST_ER_FLASH)
    else $error("erase strobe did not go busy");
  AST_NOP_READY: assert property ( // RULE_24
    can_load && wr_fall && !is_write_cmd(cmd_q) |=> ready_busy_o [*3])
    else $error("unknown command started work");
  AST_CMD_LOAD: assert property ( // RULE_04
    can_load && ls_rise && {action_select_high_i, action_select_low_i} == ppl_pkg::ACT_CMD
    |=> cmd_q == $past(data_i))
    else $error("command byte not loaded");
  AST_ADDR_HI: assert property ( // RULE_05
    can_load && ls_rise && {action_select_high_i, action_select_low_i} == ppl_pkg::ACT_ADDR && byte_select_one_i
    |=> addr_hi_q == $past(data_i) && $stable(addr_lo_q))
    else $error("high address byte not loaded");
  AST_CMD_KEPT: assert property ( // RULE_09
    state_q != ppl_pkg::ST_IDLE |=> $stable(cmd_q) && $stable(addr_hi_q))
    else $error("command lost during operation");
  AST_ENTRY_FAIL: assert property ( // RULE_02
    entry_q == ppl_pkg::EN_GUARD && hv_on_i && entry_sel != ppl_pkg::ENTRY_SEL_CODE |=> entry_q == ppl_pkg::EN_FAIL)
    else $error("select change did not block entry");
  AST_ENTRY_GUARD: assert property ( // RULE_02
    entry_q == ppl_pkg::EN_GUARD && $past(entry_q) == ppl_pkg::EN_OFF |-> !prog_mode_o [*8])
    else $error("entry before guard time");
  AST_OE_OFF: assert property ( // RULE_22
    oe_n_i |=> data_oe_n_o)
    else $error("bus driven with output enable high");
  AST_PAGE_DONE: assert property ( // RULE_11
    state_q == ppl_pkg::ST_PROG_F && $past(state_q) != ppl_pkg::ST_PROG_F
    |-> !ready_busy_o throughout ##[64:64] state_q == ppl_pkg::ST_SETTLE)
    else $error("page commit length wrong");
  AST_LOCK_LAST: assert property ( // RULE_14
    state_q == ppl_pkg::ST_ER_LOCK |-> $past(state_q) == ppl_pkg::ST_ER_EE || $past(state_q) == ppl_pkg::ST_ER_FLASH)
    else $error("locks cleared before memory erase");
  AST_PRESERVE: assert property ( // RULE_15
    state_q == ppl_pkg::ST_ER_FLASH && idx_q == ppl_pkg::FLASH_LAST && preserve |=> state_q == ppl_pkg::ST_ER_LOCK)
    else $error("eeprom erased despite preserve fuse");
  AST_BUSY_LOW: assert property ( // RULE_21
    state_q != ppl_pkg::ST_IDLE |-> !ready_busy_o)
    else $error("ready shown while busy");

  COV_ENTRY: cover property (entry_q == ppl_pkg::EN_GUARD ##[1:20] entry_q == ppl_pkg::EN_ON);
  COV_PAGE: cover property (state_q == ppl_pkg::ST_PROG_F ##[1:80] ready_busy_o);
  COV_FULL: cover property (!latch_ready_o);
  COV_ERASE: cover property (state_q == ppl_pkg::ST_ER_LOCK);
endmodule
`default_nettype wire

// ### tb/ppl_programmer.sv
// external parallel programmer model driving the loader pins
`timescale 1ns/1ns
`default_nettype none
module ppl_programmer (
  input wire logic clk_i,
  output var logic reset_low_o,
  output var logic hv_on_o,
  output var logic strobe_o,
  output var logic [1:0] act_o,
  output var logic byte_select_one_o,
  output var logic byte_select_two_o,
  output var logic latch_o,
  output var logic write_n_o,
  output var logic oe_n_o,
  output var logic [7:0] data_o
);
  initial begin
    {reset_low_o, hv_on_o, strobe_o, act_o, byte_select_one_o, byte_select_two_o, latch_o} = '0;
    write_n_o = 1'b1;
    oe_n_o = 1'b1;
    data_o = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i) #1;
  endtask
  // glitch moves a select pin inside the guard window
  task automatic enter(input bit glitch);
    hv_on_o = 1'b0;
    reset_low_o = 1'b1;
    act_o = 2'h0;
    byte_select_one_o = 1'b0;
    repeat (6) begin
      strobe_o = 1'b1;
      step(1);
      strobe_o = 1'b0;
      step(1);
    end
    step(13);
    hv_on_o = 1'b1;
    step(3);
    latch_o = glitch;
    step(1);
    latch_o = 1'b0;
    step(6250);
  endtask
  // idle action between loads so a stray strobe does nothing
  task automatic load(input logic [1:0] act, input logic one, input logic [7:0] val);
    act_o = act;
    byte_select_one_o = one;
    data_o = val;
    strobe_o = 1'b1;
    step(1);
    strobe_o = 1'b0;
    act_o = 2'h3;
    step(1);
  endtask
  task automatic latch();
    latch_o = 1'b1;
    step(1);
    latch_o = 1'b0;
    step(2);
  endtask
  task automatic wr();
    write_n_o = 1'b0;
    step(1);
    write_n_o = 1'b1;
    step(1);
  endtask
  // two cycles: byte and enable are both registered on the first edge after select
  task automatic sel(input logic b2, input logic b1, input logic oe);
    byte_select_two_o = b2;
    byte_select_one_o = b1;
    oe_n_o = oe;
    step(2);
  endtask
endmodule
`default_nettype wire

// ### tb/test_parallel_program_loader.sv
// self-checking bench of the parallel programming loader
`timescale 1ns/1ns
`default_nettype none
module test_parallel_program_loader;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rl, hv, stb, sel_one, sel_two, pl, wn, oen, doen, rdy, pm, lrdy;
  logic [1:0] act;
  logic [7:0] drv, bus, dout;
  int bad_count = 0;
  int check_count = 0;
  int seed = 9;
  logic [7:0] exp_q[$];
  int kind_q[$];
  logic [15:0] w[4];
  logic [7:0] fuse[4] = '{8'h62, 8'hFF, 8'hF9, 8'hDF};
  logic [7:0] sig[4] = '{8'hA5, 8'h5A, 8'h3C, 8'h80};
  string names[5] = '{"data", "ready_busy", "prog_mode", "data_oe_n", "latch_ready"};
  event seen;
  assign bus = doen ? drv : dout;
  initial forever #4 clk_i = ~clk_i;
  ppl_programmer prg (.clk_i(clk_i), .reset_low_o(rl), .hv_on_o(hv), .strobe_o(stb), .act_o(act),
    .byte_select_one_o(sel_one), .byte_select_two_o(sel_two), .latch_o(pl), .write_n_o(wn), .oe_n_o(oen),
    .data_o(drv));
  ppl_loader DUT (.clk_i(clk_i), .rstn_i(rstn_i), .reset_low_i(rl), .hv_on_i(hv), .load_strobe_i(stb),
    .action_select_high_i(act[1]), .action_select_low_i(act[0]), .byte_select_one_i(sel_one),
    .byte_select_two_i(sel_two), .page_latch_strobe_i(pl), .write_n_i(wn), .oe_n_i(oen), .data_i(bus),
    .data_o(dout), .data_oe_n_o(doen), .ready_busy_o(rdy), .prog_mode_o(pm), .latch_ready_o(lrdy));
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp_v);
    check_count++;
    if (got !== exp_v) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp_v, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // monitor takes the oldest note whenever the driver says a result is out
  always @(seen) begin
    case (kind_q[0])
      0: check(names[0], dout, exp_q[0]);
      1: check(names[1], {7'h00, rdy}, exp_q[0]);
      2: check(names[2], {7'h00, pm}, exp_q[0]);
      3: check(names[3], {7'h00, doen}, exp_q[0]);
      default: check(names[4], {7'h00, lrdy}, exp_q[0]);
    endcase
    void'(kind_q.pop_front());
    void'(exp_q.pop_front());
  end
  task automatic note(input int k, input logic [7:0] v);
    kind_q.push_back(k);
    exp_q.push_back(v);
    -> seen;
    #1;
  endtask
  task automatic rd(input logic b2, input logic b1, input logic [7:0] v);
    prg.sel(b2, b1, 1'b0);
    note(0, v);
    note(3, 8'h00);
    prg.sel(b2, b1, 1'b1);
  endtask
  // bounded wait; a hang counts as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 12000) begin
      prg.step(1);
      n++;
    end
    if (n == 12000) begin
      bad_count++;
      complete_run();
    end
    note(1, 8'h01);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    note(1, 8'h01);
    prg.enter(1'b1);
    note(2, 8'h00);
    prg.enter(1'b0);
    note(2, 8'h01);
    $display("entry tests done");
    prg.load(2'h2, 1'b0, 8'h04);
    for (int i = 0; i < 4; i++)
      rd(i[1], i[0], fuse[i]);
    prg.load(2'h2, 1'b0, 8'h08);
    prg.load(2'h3, 1'b0, 8'h02);
    for (int i = 0; i < 3; i++) begin
      prg.load(2'h0, 1'b0, 8'(i));
      rd(1'b0, 1'b0, sig[i]);
    end
    prg.load(2'h0, 1'b0, 8'h00);
    rd(1'b0, 1'b1, sig[3]);
    $display("read tests done");
    prg.load(2'h2, 1'b0, 8'h80);
    prg.wr();
    note(1, 8'h00);
    wait_ready();
    prg.load(2'h2, 1'b0, 8'h10);
    for (int i = 0; i < 4; i++) begin
      w[i] = 16'($random(seed));
      prg.load(2'h0, 1'b0, 8'h40 + 8'(i));
      prg.load(2'h1, 1'b0, w[i][7:0]);
      prg.load(2'h1, 1'b1, w[i][15:8]);
      prg.latch();
    end
    note(4, 8'h01);
    prg.load(2'h0, 1'b1, 8'h01);
    prg.wr();
    note(1, 8'h00);
    wait_ready();
    prg.load(2'h2, 1'b0, 8'h02);
    for (int i = 0; i < 4; i++) begin
      prg.load(2'h0, 1'b0, 8'h40 + 8'(i));
      rd(1'b0, 1'b0, w[i][7:0]);
      rd(1'b0, 1'b1, w[i][15:8]);
    end
    prg.load(2'h0, 1'b0, 8'h44);
    rd(1'b0, 1'b0, 8'hFF);
    $display("erase and flash tests done");
    prg.load(2'h2, 1'b0, 8'h11);
    prg.load(2'h0, 1'b1, 8'h00);
    prg.load(2'h0, 1'b0, 8'h06);
    prg.load(2'h1, 1'b0, w[1][7:0]);
    prg.latch();
    prg.wr();
    note(1, 8'h00);
    wait_ready();
    prg.load(2'h2, 1'b0, 8'h03);
    rd(1'b0, 1'b0, w[1][7:0]);
    prg.load(2'h2, 1'b0, 8'h20);
    prg.load(2'h1, 1'b0, 8'hFC);
    prg.wr();
    wait_ready();
    prg.load(2'h2, 1'b0, 8'h40);
    prg.load(2'h1, 1'b0, 8'hD7);
    prg.sel(1'b0, 1'b1, 1'b1);
    prg.wr();
    wait_ready();
    prg.load(2'h2, 1'b0, 8'h04);
    rd(1'b0, 1'b1, 8'hFC);
    rd(1'b1, 1'b1, 8'hD7);
    prg.load(2'h2, 1'b0, 8'h80);
    prg.wr();
    wait_ready();
    prg.load(2'h2, 1'b0, 8'h04);
    rd(1'b0, 1'b1, 8'hFF);
    rd(1'b1, 1'b1, 8'hD7);
    prg.load(2'h2, 1'b0, 8'h03);
    rd(1'b0, 1'b0, w[1][7:0]);
    $display("eeprom and fuse tests done");
    prg.load(2'h2, 1'b0, 8'h55);
    prg.wr();
    note(1, 8'h01);
    $display("unknown command test done");
    complete_run();
  end
endmodule
`default_nettype wire
